// [tb_vdc_ctrl.sv]
// self-checking bench for the converter register control
// assumes vdc_pkg and vdc_ctrl are compiled first
`timescale 1ns/1ps
module tb_vdc_ctrl;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic SFR_WR = 1'b0;
  logic SFR_RD = 1'b0;
  logic [7:0] SFR_RDATA;
  logic SFR_HIT;
  logic [11:0] DAC_CODE;
  logic DAC_ENABLE, DAC_BUFFER_HIZ, DAC_RANGE_SUPPLY, DAC_PIN_ALTERNATE, DAC_PIN_DEFAULT;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] lo, hi, c;
  logic [11:0] exp_c;
  vdc_ctrl DUT (.SYS_CLK(SYS_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .DAC_CODE(DAC_CODE),
    .DAC_ENABLE(DAC_ENABLE), .DAC_BUFFER_HIZ(DAC_BUFFER_HIZ), .DAC_RANGE_SUPPLY(DAC_RANGE_SUPPLY),
    .DAC_PIN_ALTERNATE(DAC_PIN_ALTERNATE), .DAC_PIN_DEFAULT(DAC_PIN_DEFAULT));
  initial forever #4 SYS_CLK = ~SYS_CLK;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access, strobe held over exactly one rising edge; answer looked at in the cycle after
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic [7:0] exp);
    @(negedge SYS_CLK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = w;
    SFR_RD = !w;
    @(negedge SYS_CLK);
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    chk({11'h000, SFR_HIT}, {11'h000, (a >= 8'hFB && a <= 8'hFD)}, "hit");
    chk({4'h0, SFR_RDATA}, {4'h0, exp}, "read data");
  endtask
  function automatic logic [4:0] ana(input logic [7:0] cc);
    return {cc[0], !cc[0], cc[2], cc[4], !cc[4]};
  endfunction
  function automatic logic [11:0] code_of(input logic [7:0] cc, input logic [7:0] l, input logic [7:0] h);
    if (!cc[1]) return 12'h000;
    return cc[3] ? {l, 4'h0} : {h[3:0], l};
  endfunction
  task automatic chk_ana(input logic [7:0] cc);
    chk({7'h00, DAC_ENABLE, DAC_BUFFER_HIZ, DAC_RANGE_SUPPLY, DAC_PIN_ALTERNATE, DAC_PIN_DEFAULT},
      {7'h00, ana(cc)}, "analog controls");
  endtask
  task automatic results;
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    c = 8'($urandom(25));
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST = 1'b0;
    chk_ana(8'h00);
    chk(DAC_CODE, 12'h000, "code at reset");
    bus(8'hFB, 8'h00, 1'b0, 8'h00);
    bus(8'hFC, 8'h00, 1'b0, 8'h00);
    bus(8'hFD, 8'h00, 1'b0, 8'h00);
    bus(8'hFC, 8'h5A, 1'b1, 8'h00);
    bus(8'hFB, 8'hA5, 1'b1, 8'h00);
    bus(8'hFB, 8'h00, 1'b0, 8'h00);
    chk(DAC_CODE, 12'h000, "code while cleared");
    bus(8'h10, 8'hFF, 1'b1, 8'h00);
    bus(8'h10, 8'h00, 1'b0, 8'h00);
    bus(8'hFD, 8'hFF, 1'b1, 8'h00);
    bus(8'hFD, 8'h00, 1'b0, 8'h1F);
    exp_c = 12'h000;
    for (int i = 0; i < 24; i++) begin
      c = (8'($urandom) & 8'h1C) | 8'h03;
      if (i < 2) c[3] = i[0];
      hi = 8'($urandom);
      lo = (i == 0) ? 8'hFF : 8'($urandom);
      bus(8'hFD, c, 1'b1, 8'h00);
      chk_ana(c);
      bus(8'hFC, hi, 1'b1, 8'h00);
      chk(DAC_CODE, exp_c, "code after high write");
      bus(8'hFB, lo, 1'b1, 8'h00);
      exp_c = code_of(c, lo, hi);
      chk(DAC_CODE, exp_c, "code after low write");
      bus(8'hFC, 8'h00, 1'b0, hi);
      bus(8'hFB, 8'h00, 1'b0, lo);
    end
    bus(8'hFD, 8'h01, 1'b1, 8'h00);
    chk(DAC_CODE, 12'h000, "code after clear");
    bus(8'hFC, 8'h00, 1'b0, 8'h00);
    bus(8'hFD, 8'h00, 1'b1, 8'h00);
    chk_ana(8'h00);
    results();
  end
endmodule // tb_vdc_ctrl

// [vdc_ctrl.sv]
// register control of the 12-bit voltage output converter
// assumes a single-cycle sfr write strobe and combinational-free read data capture
//
// Contract
// - 12-bit code updates on low register write
// - code right-justified, low byte bits 7..0
// - control bit 4 selects output pin
// - control bit 3: low byte to msbs
// - control bit 2 selects output range
// - clear bit zero holds data at zero
// - enable bit zero powers down, hi-z
// - control bits 7..5 reserved, no function
// - data registers at FBH, FCH, reset 00H
// - converter starts disabled and three-stated
`timescale 1ns/1ps
module vdc_ctrl #(
  parameter int CODE_WIDTH = vdc_pkg::CODE_W
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // special-function register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  // analog side
  output logic [CODE_WIDTH-1:0] DAC_CODE,
  output logic DAC_ENABLE,
  output logic DAC_BUFFER_HIZ,
  output logic DAC_RANGE_SUPPLY,
  output logic DAC_PIN_ALTERNATE,
  output logic DAC_PIN_DEFAULT
);
  // the byte split below only serves a 12-bit converter
  if (CODE_WIDTH != vdc_pkg::CODE_W) begin : g_bad_width
    $error("vdc_ctrl serves a 12-bit code only");
  end

  // byte split of the code; only the low nibble of the high register feeds it
  localparam int BYTE_W = 8;
  localparam int NIB_W = CODE_WIDTH - BYTE_W;
  localparam int CTRL_W = $bits(vdc_pkg::vdc_ctrl_s);

  logic [7:0] data_low_r;
  logic [7:0] data_high_r;
  logic [7:0] control_r;
  logic [CODE_WIDTH-1:0] code_r;
  logic [CODE_WIDTH-1:0] code_nxt;
  vdc_pkg::vdc_ctrl_s ctrl;
  vdc_pkg::vdc_analog_s ana_nxt;

  wire sel_low = SFR_ADDR == vdc_pkg::ADDR_DATA_LOW;
  wire sel_high = SFR_ADDR == vdc_pkg::ADDR_DATA_HIGH;
  wire sel_ctrl = SFR_ADDR == vdc_pkg::ADDR_CONTROL;
  wire wr_low = SFR_WR && sel_low;
  wire wr_high = SFR_WR && sel_high;
  wire wr_ctrl = SFR_WR && sel_ctrl;
  wire hit = sel_low || sel_high || sel_ctrl;

  assign ctrl = vdc_pkg::vdc_ctrl_s'(control_r[CTRL_W-1:0]);
  wire clear_active = !ctrl.data_clear_n;

  // reserved bits are dropped on write so they can never steer anything
  wire [7:0] ctrl_wdata = SFR_WDATA & vdc_pkg::CTRL_USED_MASK;

  // a clear written in the same cycle as data takes precedence
  wire clr_nxt = wr_ctrl ? !ctrl_wdata[vdc_pkg::BIT_CLEAR_N] : clear_active;
  wire [7:0] low_nxt = clr_nxt ? vdc_pkg::RST_DATA : (wr_low ? SFR_WDATA : data_low_r);
  wire [7:0] high_nxt = clr_nxt ? vdc_pkg::RST_DATA : (wr_high ? SFR_WDATA : data_high_r);
  wire byte_mode_nxt = wr_ctrl ? ctrl_wdata[vdc_pkg::BIT_BYTE_MODE] : ctrl.byte_mode_select;

  // code latches on a low write and zeroes on a clear; high alone stays hidden
  wire [CODE_WIDTH-1:0] code_full = {data_high_r[NIB_W-1:0], SFR_WDATA};
  wire [CODE_WIDTH-1:0] code_byte = {SFR_WDATA, {NIB_W{1'b0}}};
  always_comb begin
    code_nxt = code_r;
    if (clr_nxt)
      code_nxt = '0;
    else if (wr_low)
      code_nxt = byte_mode_nxt ? code_byte : code_full;
  end

  wire [7:0] rd_mux = sel_low ? data_low_r :
                      sel_high ? data_high_r :
                      sel_ctrl ? control_r : 8'h00;

  always_comb begin
    ana_nxt.code = code_nxt;
    ana_nxt.enable = wr_ctrl ? ctrl_wdata[vdc_pkg::BIT_ENABLE] : ctrl.converter_enable;
    ana_nxt.buffer_hiz = !ana_nxt.enable;
    ana_nxt.range_supply = wr_ctrl ? ctrl_wdata[vdc_pkg::BIT_RANGE] : ctrl.output_range_select;
    ana_nxt.pin_alternate = wr_ctrl ? ctrl_wdata[vdc_pkg::BIT_PIN] : ctrl.output_pin_select;
    ana_nxt.pin_default = !ana_nxt.pin_alternate;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      control_r <= vdc_pkg::RST_CONTROL;
      data_low_r <= vdc_pkg::RST_DATA;
      data_high_r <= vdc_pkg::RST_DATA;
      code_r <= '0;
    end else begin
      if (wr_ctrl) control_r <= ctrl_wdata;
      data_low_r <= low_nxt;
      data_high_r <= high_nxt;
      code_r <= code_nxt;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
      SFR_HIT <= 1'b0;
      DAC_CODE <= '0;
      DAC_ENABLE <= 1'b0;
      DAC_BUFFER_HIZ <= 1'b1;
      DAC_RANGE_SUPPLY <= 1'b0;
      DAC_PIN_ALTERNATE <= 1'b0;
      DAC_PIN_DEFAULT <= 1'b1;
    end else begin
      SFR_RDATA <= SFR_RD ? rd_mux : 8'h00;
      SFR_HIT <= (SFR_RD || SFR_WR) && hit;
      DAC_CODE <= ana_nxt.code;
      DAC_ENABLE <= ana_nxt.enable;
      DAC_BUFFER_HIZ <= ana_nxt.buffer_hiz;
      DAC_RANGE_SUPPLY <= ana_nxt.range_supply;
      DAC_PIN_ALTERNATE <= ana_nxt.pin_alternate;
      DAC_PIN_DEFAULT <= ana_nxt.pin_default;
    end
  end

  // high write alone must not move the output
  high_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_high && !clr_nxt) |=> $stable(DAC_CODE))
    else $error("code changed on high register write");

  low_full_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_low && !clr_nxt && !byte_mode_nxt) |=> DAC_CODE == {$past(data_high_r[3:0]), $past(SFR_WDATA)})
    else $error("12-bit code not right-justified");

  low_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_low && !clr_nxt && byte_mode_nxt) |=> DAC_CODE == {$past(SFR_WDATA), 4'h0})
    else $error("8-bit code not routed to msbs");

  clear_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    clear_active |-> (data_low_r == 8'h00 && data_high_r == 8'h00 && code_r == '0))
    else $error("data not held at zero under clear");

  hiz_off_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    DAC_BUFFER_HIZ == !DAC_ENABLE)
    else $error("buffer not three-stated while disabled");

  enable_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl |=> DAC_ENABLE == $past(SFR_WDATA[vdc_pkg::BIT_ENABLE]))
    else $error("enable does not follow control write");

  pin_sel_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    DAC_PIN_ALTERNATE != DAC_PIN_DEFAULT && DAC_PIN_ALTERNATE == ctrl.output_pin_select)
    else $error("output pin routing wrong");

  range_sel_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    DAC_RANGE_SUPPLY == ctrl.output_range_select)
    else $error("range select wrong");

  reserved_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    control_r[7:5] == 3'h0)
    else $error("reserved control bits stored");

  low_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_RD && sel_low) |=> SFR_RDATA == $past(data_low_r))
    else $error("low register read wrong");

  // strobe to a mapped address answers one cycle later
  hit_map_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    ((SFR_WR || SFR_RD) && hit)
    |=> SFR_HIT)
    else $error("mapped access not acknowledged");

  // no strobe or an unmapped address gives no hit
  hit_miss_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!(SFR_WR || SFR_RD) || !hit)
    |=> !SFR_HIT)
    else $error("hit raised without a mapped access");

  // read data returns to zero so a shared read tree stays clean
  rdata_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !SFR_RD
    |=> SFR_RDATA == 8'h00)
    else $error("read data not zero when idle");

  unmapped_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_RD && !hit)
    |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");

  // high register keeps all eight bits on read back
  high_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_RD && sel_high)
    |=> SFR_RDATA == $past(data_high_r))
    else $error("high register read wrong");

  ctrl_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_RD && sel_ctrl)
    |=> SFR_RDATA == $past(control_r))
    else $error("control register read wrong");

  // writing the clear bit low zeroes data and code together
  clear_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_ctrl && !SFR_WDATA[vdc_pkg::BIT_CLEAR_N])
    |=> (DAC_CODE == '0 && data_low_r == vdc_pkg::RST_DATA && data_high_r == vdc_pkg::RST_DATA))
    else $error("clear write did not zero data");

  // data writes are swallowed while clear is held
  clear_low_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_low && clr_nxt)
    |=> DAC_CODE == '0)
    else $error("code moved under clear");

  // releasing clear must not invent a code
  clear_release_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_ctrl && SFR_WDATA[vdc_pkg::BIT_CLEAR_N] && clear_active)
    |=> (DAC_CODE == '0 && data_low_r == vdc_pkg::RST_DATA))
    else $error("code not zero after clear release");

  low_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_low && !clr_nxt)
    |=> data_low_r == $past(SFR_WDATA))
    else $error("low register write lost");

  // high write lands in its register but stays hidden
  high_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_high && !clr_nxt)
    |=> data_high_r == $past(SFR_WDATA))
    else $error("high register write lost");

  // only a low write or a clear may move the code
  code_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!wr_low && !clr_nxt)
    |=> $stable(DAC_CODE))
    else $error("code moved without a low write");

  byte_nibble_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_low && !clr_nxt && byte_mode_nxt)
    |=> DAC_CODE[NIB_W-1:0] == '0)
    else $error("8-bit code low bits not zero");

  // analog controls follow a control write one cycle later
  range_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl
    |=> DAC_RANGE_SUPPLY == $past(SFR_WDATA[vdc_pkg::BIT_RANGE]))
    else $error("range does not follow control write");

  pin_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl
    |=> DAC_PIN_ALTERNATE == $past(SFR_WDATA[vdc_pkg::BIT_PIN]))
    else $error("pin does not follow control write");

  enable_rise_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_ctrl && SFR_WDATA[vdc_pkg::BIT_ENABLE])
    |=> (DAC_ENABLE && !DAC_BUFFER_HIZ))
    else $error("buffer still three-stated after enable");

  // analog controls never move without a control write
  analog_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !wr_ctrl
    |=> $stable({DAC_ENABLE, DAC_RANGE_SUPPLY, DAC_PIN_ALTERNATE}))
    else $error("analog controls moved without a control write");

  // converter stays off until software enables it
  enable_wait_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl.converter_enable && !wr_ctrl)
    |=> !DAC_ENABLE)
    else $error("converter enabled without software");

  ctrl_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl
    |=> control_r == ($past(SFR_WDATA) & vdc_pkg::CTRL_USED_MASK))
    else $error("control write not stored");

  // unmapped writes touch no register
  unmapped_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SFR_WR && !hit)
    |=> ($stable(control_r) && $stable(data_low_r) && $stable(data_high_r)))
    else $error("unmapped write changed a register");

  idle_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !SFR_WR
    |=> ($stable(control_r) && $stable(data_low_r) && $stable(data_high_r)))
    else $error("register changed without a write");

  // one check per control bit: used bits store, reserved bits never do
  for (genvar b = 0; b < BYTE_W; b++) begin : g_ctrl_bit
    if (vdc_pkg::CTRL_USED_MASK[b]) begin : g_used
      bit_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_ctrl |=> control_r[b] == $past(SFR_WDATA[b]))
        else $error("used control bit not stored");
    end else begin : g_reserved
      bit_drop_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_ctrl |=> !control_r[b])
        else $error("reserved control bit stored");
    end
  end
endmodule // vdc_ctrl

// [vdc_pkg.sv]
// package for the voltage converter register control
// assumes an 8-bit special-function register bus on the core clock
package vdc_pkg;
  localparam logic [7:0] ADDR_DATA_LOW = 8'hFB;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'hFC;
  localparam logic [7:0] ADDR_CONTROL = 8'hFD;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] CTRL_USED_MASK = 8'h1F;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CLEAR_N = 1;
  localparam int BIT_RANGE = 2;
  localparam int BIT_BYTE_MODE = 3;
  localparam int BIT_PIN = 4;
  localparam int CODE_W = 12;

  typedef struct packed {
    logic output_pin_select;
    logic byte_mode_select;
    logic output_range_select;
    logic data_clear_n;
    logic converter_enable;
  } vdc_ctrl_s;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic enable;
    logic buffer_hiz;
    logic range_supply;
    logic pin_alternate;
    logic pin_default;
  } vdc_analog_s;
endpackage
